// File: pkg/spi_ctl_defs.svh
// Purpose: register offsets, field positions, reset values and counts
// Assumes: 8-bit registers on a plain strobe port
// Notes:   definitions only
`ifndef SPI_CTL_DEFS_SVH
`define SPI_CTL_DEFS_SVH

// register offsets on the 2-bit address port
`define SPI_ADDR_CTRL   2'h0
`define SPI_ADDR_STAT   2'h1
`define SPI_ADDR_DATA   2'h2

// control_reg fields
`define SPI_C_RXIE      7
`define SPI_C_MASTER_SELECT_ALIAS      5
`define SPI_C_CPOL      4
`define SPI_C_CLOCK_PHASE_SELECT      3
`define SPI_C_WOM       2
`define SPI_C_EN        1
`define SPI_C_TXIE      0
`define SPI_C_MASK      8'hbf
`define SPI_CTRL_RST    8'h28

// status_control_reg fields
`define SPI_S_RXF       7
`define SPI_S_ERROR_IRQ_ENABLE     6
`define SPI_S_OVR       5
`define SPI_S_MODE_FAULT_FLAG      4
`define SPI_S_TXE       3
`define SPI_S_MFDE      2
`define SPI_S_BAUD_HI   1
`define SPI_S_BAUD_LO   0

// half period of the master serial clock, in bus clocks, before scaling
`define SPI_HALF_BASE   5'h02
// clock edges in one byte: eight cycles, two edges each
`define SPI_EDGES       5'h10

`endif

// File: pkg/spi_ctl_pkg.sv
// Purpose: shared types of the serial unit control block
// Assumes: nothing
// Notes:   constants live in spi_ctl_defs.svh
package spi_ctl_pkg;

  // transfer engine states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } st_type;

  // the three serial pins the unit may own
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
  } pin_type;

endpackage

// File: rtl/spi_pin_sync.sv
// Purpose: two-flop synchroniser for the serial pins
// Assumes: bit order {miso, mosi, sck, select_n}
// Notes:   only the second stage leaves this module
`timescale 1ns/10ps
module spi_pin_sync (
  input  wire logic       i_mclk,    // bus clock
  input  wire logic       i_sys_rst, // sync reset, high
  input  wire logic [3:0] i_raw,     // pins from outside
  output logic      [3:0] o_sync     // pins after two flops
);

  logic [3:0] meta_q;

  // one flop pair per pin; select idles high so it resets high
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_bit
      always_ff @(posedge i_mclk)
      begin
        if (i_sys_rst)
        begin
          meta_q[g] <= (g == 0) ? 1'b1 : 1'b0;
          o_sync[g] <= (g == 0) ? 1'b1 : 1'b0;
        end
        else
        begin
          meta_q[g] <= i_raw[g];
          o_sync[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule

// File: rtl/spi_ctl.sv
// Purpose: control, status, fault and pin ownership of a byte serial unit
// Assumes: 200 MHz bus clock; pins are asynchronous to it
// Notes:   master clock is divided from the bus clock
//
// How it works
// - phase 0 deselect faults; phase 1 deselect alone does not
// - slave fault requests error irq, keeps enable
// - deselected slave floats output, ignores clocks
// - fault clears after status read then control write
// - tx irq needs tx enable and unit enable
// - rx irq ignores unit enable
// - one error enable gates overrun and fault
// - rx full clears: status read, then data read
// - only a data write clears tx empty
// - completed byte into rx buffer sets rx full
// - tx buffer into shifter sets tx empty
// - system reset restores every bit
// - disabled: tx empty held, shifter and counter cleared
// - disabled keeps control bits and rx full, overrun and fault flags
// - master fault clears unit enable
// - wait: runs, registers closed, irq wakes
// - stop halts and holds; reset aborts
// - break without clear enable freezes flag clears
// - data write in frozen break does nothing
// - slave output driven only as selected slave
// - enabled unit owns pin directions
// - eight clock cycles move one byte each way
// - master bit resets to master
// - master sees select low: fault
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "spi_ctl_defs.svh"
module spi_ctl (
  input  wire logic       i_mclk,      // bus clock, 200 MHz
  input  wire logic       i_sys_rst,   // sync reset, high
  input  wire logic [1:0] i_addr,      // register address
  input  wire logic [7:0] i_wdata,     // write data
  input  wire logic       i_wr,        // write strobe
  input  wire logic       i_rd,        // read strobe
  output logic      [7:0] o_rdata,     // read data, cycle after strobe
  input  wire logic       i_wait,      // processor in wait mode
  input  wire logic       i_stop,      // processor in stop mode
  input  wire logic       i_break,     // debug break active
  input  wire logic       i_brk_clr_en,// break_clear_enable
  input  wire logic       i_ss_n,      // select pin, low active
  input  wire logic       i_sck,       // serial_clock_pin in
  output logic            o_sck,       // serial_clock_pin out
  output logic            o_sck_oe_n,  // low while driving
  input  wire logic       i_mosi,      // master out pin in
  output logic            o_mosi,      // master out pin out
  output logic            o_mosi_oe_n, // low while driving
  input  wire logic       i_miso,      // slave out pin in
  output logic            o_miso,      // slave out pin out
  output logic            o_miso_oe_n, // low while driving
  output logic            o_pins_owned,// unit owns pin directions
  output logic            o_tx_irq,    // transmitter request
  output logic            o_rx_irq,    // receiver/error request
  output logic            o_wake       // wake from wait
);

  logic [3:0]          sync_w;
  logic [7:0]          ctrl_q;
  logic                error_irq_enable_q, mfde_q;
  logic [1:0]          baud_q;
  logic                rxf_q, ovr_q, mode_fault_flag_q, txe_q;
  logic                rxf_arm_q, ovr_arm_q, mode_fault_flag_arm_q;
  logic [7:0]          tx_buf_q, rx_buf_q, shreg_q;
  logic                bit_q, sck_prev_q, ss_low_prev_q, sck_int_q;
  logic [4:0]          edge_cnt_q, div_q;
  spi_ctl_pkg::st_type st_q;
  spi_ctl_pkg::pin_type pout_d, poe_n_d;

  // edge number parity decides sample versus shift for each phase
  function automatic logic is_sample(input logic clock_phase_select, input logic [4:0] n);
    is_sample = n[0] ^ clock_phase_select;
  endfunction

  // pins pass two flops first; only stage two is read here
  spi_pin_sync u_sync (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_raw     ({i_miso, i_mosi, i_sck, i_ss_n}),
    .o_sync    (sync_w)
  );

  // register access; the port is closed while in wait
  wire acc     = ~i_wait & ~i_stop;
  wire frz     = i_break & ~i_brk_clr_en;
  wire wr_ctrl = i_wr & acc & (i_addr == `SPI_ADDR_CTRL);
  wire wr_stat = i_wr & acc & (i_addr == `SPI_ADDR_STAT);
  wire wr_data = i_wr & acc & (i_addr == `SPI_ADDR_DATA) & ~frz;
  wire rd_stat = i_rd & acc & (i_addr == `SPI_ADDR_STAT);
  wire rd_data = i_rd & acc & (i_addr == `SPI_ADDR_DATA);

  // decoded control
  wire en     = ctrl_q[`SPI_C_EN];
  wire master_select_alias   = ctrl_q[`SPI_C_MASTER_SELECT_ALIAS];
  wire clock_phase_select   = ctrl_q[`SPI_C_CLOCK_PHASE_SELECT];
  wire cpol   = ctrl_q[`SPI_C_CPOL];
  wire wom    = ctrl_q[`SPI_C_WOM];
  wire run    = (st_q == spi_ctl_pkg::ST_RUN);
  wire ss_low = ~sync_w[0];
  wire s_sck  = sync_w[1];
  wire in_now = master_select_alias ? sync_w[3] : sync_w[2];

  // edge events; a deselected slave sees no clocks at all
  wire [4:0] half_w  = `SPI_HALF_BASE << baud_q;
  wire m_tick  = run & master_select_alias & (div_q == 5'h00);
  wire s_edge  = en & ~master_select_alias & ss_low & (s_sck != sck_prev_q);
  wire s_lead  = s_edge & (s_sck != cpol);
  wire s_start0 = en & ~master_select_alias & ~clock_phase_select & ~run & ss_low & ~ss_low_prev_q;
  wire s_start1 = en & ~master_select_alias & clock_phase_select & ~run & s_lead;
  wire m_start  = en & master_select_alias & ~run & ~txe_q;
  wire start    = m_start | s_start0 | s_start1;
  wire load_tx  = start & ~txe_q;
  wire edge_evt = run & (master_select_alias ? m_tick : s_edge);
  wire [4:0] n_w = edge_cnt_q + 5'h01;
  wire do_samp  = edge_evt & is_sample(clock_phase_select, n_w);
  wire done     = edge_evt & (n_w == `SPI_EDGES);
  wire do_shift = edge_evt & ~is_sample(clock_phase_select, n_w) & (n_w != 5'h01) & ~done;
  wire fin_bit  = clock_phase_select ? in_now : bit_q;
  wire [7:0] fin_byte = {shreg_q[6:0], fin_bit};
  wire s_abort  = run & ~master_select_alias & ~ss_low;

  // faults: master sees select low, or selected slave loses select
  wire m_fault  = en & master_select_alias & mfde_q & ss_low;
  wire s_fault  = en & ~master_select_alias & mfde_q & s_abort;
  wire fault    = m_fault | s_fault;

  // overrun keeps the unread byte; later bytes drop until cleared
  wire rx_commit = done & ~rxf_q & ~ovr_q;
  wire ovr_set   = done & rxf_q;

  // control register: master fault drops the enable, slave fault not
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      ctrl_q <= `SPI_CTRL_RST;
    else if (~i_stop)
    begin
      if (wr_ctrl)
        ctrl_q <= i_wdata & `SPI_C_MASK;
      if (m_fault)
        ctrl_q[`SPI_C_EN] <= 1'b0;
    end
  end

  // status control bits survive disable; only reset or a status write changes them
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      error_irq_enable_q <= 1'b0;
      mfde_q  <= 1'b0;
      baud_q  <= 2'h0;
    end
    else if (~i_stop & wr_stat)
    begin
      error_irq_enable_q <= i_wdata[`SPI_S_ERROR_IRQ_ENABLE];
      mfde_q  <= i_wdata[`SPI_S_MFDE];
      baud_q  <= i_wdata[`SPI_S_BAUD_HI:`SPI_S_BAUD_LO];
    end
  end

  // two-step clears arm on a status read; frozen break blocks both steps
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      mode_fault_flag_q <= 1'b0;
      rxf_arm_q <= 1'b0;
      ovr_arm_q <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end
    else if (~i_stop)
    begin
      if (rd_stat & rxf_q & ~frz)
        rxf_arm_q <= 1'b1;
      else if (rd_data & ~frz)
        rxf_arm_q <= 1'b0;
      if (rd_stat & ovr_q & ~frz)
        ovr_arm_q <= 1'b1;
      else if (rd_data & ~frz)
        ovr_arm_q <= 1'b0;
      // a fault anywhere in the sequence cancels it
      if (fault)
        mode_fault_flag_arm_q <= 1'b0;
      else if (rd_stat & mode_fault_flag_q & ~frz)
        mode_fault_flag_arm_q <= 1'b1;
      else if (wr_ctrl & ~frz)
        mode_fault_flag_arm_q <= 1'b0;
      // set wins over a clear in the same cycle
      if (rx_commit)
        rxf_q <= 1'b1;
      else if (rd_data & rxf_arm_q & ~frz)
        rxf_q <= 1'b0;
      if (ovr_set)
        ovr_q <= 1'b1;
      else if (rd_data & ovr_arm_q & ~frz)
        ovr_q <= 1'b0;
      if (fault)
        mode_fault_flag_q <= 1'b1;
      else if (wr_ctrl & mode_fault_flag_arm_q & ~frz)
        mode_fault_flag_q <= 1'b0;
    end
  end

  // tx empty: set by a load, held while disabled, cleared by data write
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      txe_q    <= 1'b1;
      tx_buf_q <= 8'h00;
    end
    else if (~i_stop)
    begin
      if (wr_data)
        tx_buf_q <= i_wdata;
      if (~en | load_tx)
        txe_q <= 1'b1;
      else if (wr_data)
        txe_q <= 1'b0;
    end
  end

  // receive buffer only takes bytes with no pending unread one
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
      rx_buf_q <= 8'h00;
    else if (~i_stop & rx_commit)
      rx_buf_q <= fin_byte;
  end

  // transfer engine; disable or deselect aborts mid-byte
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      st_q       <= spi_ctl_pkg::ST_IDLE;
      shreg_q    <= 8'h00;
      bit_q      <= 1'b0;
      edge_cnt_q <= 5'h00;
    end
    else if (~i_stop)
    begin
      if (~en)
      begin
        st_q       <= spi_ctl_pkg::ST_IDLE;
        shreg_q    <= 8'h00;
        edge_cnt_q <= 5'h00;
      end
      else if (s_abort | done)
      begin
        st_q       <= spi_ctl_pkg::ST_IDLE;
        edge_cnt_q <= 5'h00;
      end
      else if (start)
      begin
        st_q       <= spi_ctl_pkg::ST_RUN;
        edge_cnt_q <= s_start1 ? 5'h01 : 5'h00;
        if (load_tx)
          shreg_q <= tx_buf_q;
      end
      else if (edge_evt)
      begin
        edge_cnt_q <= n_w;
        if (do_samp)
          bit_q <= in_now;
        if (do_shift)
          shreg_q <= {shreg_q[6:0], bit_q};
      end
    end
  end

  // master clock divider and pin edge history
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      div_q         <= 5'h00;
      sck_int_q     <= 1'b0;
      sck_prev_q    <= 1'b0;
      ss_low_prev_q <= 1'b0;
    end
    else if (~i_stop)
    begin
      sck_prev_q    <= s_sck;
      ss_low_prev_q <= ss_low;
      if (~run | ~en)
      begin
        div_q     <= half_w - 5'h01;
        sck_int_q <= 1'b0;
      end
      else if (m_tick)
      begin
        div_q     <= half_w - 5'h01;
        sck_int_q <= ~sck_int_q;
      end
      else
        div_q <= div_q - 5'h01;
    end
  end

  // pin values and enables; wired-or drives only zeros
  always_comb
  begin
    pout_d.sck   = cpol ^ sck_int_q;
    pout_d.mosi  = shreg_q[7];
    pout_d.miso  = shreg_q[7];
    poe_n_d.sck  = ~(en & master_select_alias & (~wom | ~pout_d.sck));
    poe_n_d.mosi = ~(en & master_select_alias & (~wom | ~pout_d.mosi));
    poe_n_d.miso = ~(en & ~master_select_alias & ss_low & (~wom | ~pout_d.miso));
  end

  // read mux; reserved and unmapped read zero
  wire [7:0] stat_w = {rxf_q, error_irq_enable_q, ovr_q, mode_fault_flag_q, txe_q, mfde_q, baud_q};
  wire [7:0] rd_w   = (i_addr == `SPI_ADDR_CTRL) ? ctrl_q :
                      (i_addr == `SPI_ADDR_STAT) ? stat_w :
                      (i_addr == `SPI_ADDR_DATA) ? rx_buf_q : 8'h00;
  wire tx_req = txe_q & ctrl_q[`SPI_C_TXIE] & en;
  wire rx_req = (rxf_q & ctrl_q[`SPI_C_RXIE]) |
                ((ovr_q | mode_fault_flag_q) & error_irq_enable_q);

  // every output leaves from a flop
  always_ff @(posedge i_mclk)
  begin
    if (i_sys_rst)
    begin
      o_rdata      <= 8'h00;
      o_sck        <= 1'b0;
      o_mosi       <= 1'b0;
      o_miso       <= 1'b0;
      o_sck_oe_n   <= 1'b1;
      o_mosi_oe_n  <= 1'b1;
      o_miso_oe_n  <= 1'b1;
      o_pins_owned <= 1'b0;
      o_tx_irq     <= 1'b0;
      o_rx_irq     <= 1'b0;
      o_wake       <= 1'b0;
    end
    else if (~i_stop)
    begin
      o_rdata      <= (i_rd & acc) ? rd_w : 8'h00;
      o_sck        <= pout_d.sck;
      o_mosi       <= pout_d.mosi;
      o_miso       <= pout_d.miso;
      o_sck_oe_n   <= poe_n_d.sck;
      o_mosi_oe_n  <= poe_n_d.mosi;
      o_miso_oe_n  <= poe_n_d.miso;
      o_pins_owned <= en;
      o_tx_irq     <= tx_req;
      o_rx_irq     <= rx_req;
      o_wake       <= i_wait & (tx_req | rx_req);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  AST_TX_IRQ: assert property (!i_stop |=> o_tx_irq == $past(tx_req))
    else $error("tx request mismatch");
  AST_RX_IRQ: assert property (
    (!i_stop && rxf_q && ctrl_q[`SPI_C_RXIE] && !en) |=> o_rx_irq)
    else $error("rx request lost while disabled");
  AST_ERR_IRQ: assert property (
    (!i_stop && (ovr_q || mode_fault_flag_q) && error_irq_enable_q) |=> o_rx_irq)
    else $error("error request missing");
  AST_SS_FLOAT: assert property (
    (!i_stop && !master_select_alias && !ss_low) |=> o_miso_oe_n)
    else $error("slave output driven while deselected");
  AST_M_FAULT: assert property (
    (!i_stop && m_fault) |=> (mode_fault_flag_q && !ctrl_q[`SPI_C_EN]) ##1 (o_rx_irq == error_irq_enable_q))
    else $error("master fault handling wrong");
  AST_S_FAULT: assert property (
    (!i_stop && s_fault && !wr_ctrl) |=> (mode_fault_flag_q && ctrl_q[`SPI_C_EN]))
    else $error("slave fault handling wrong");
  AST_CPHA0_START: assert property (
    (!i_stop && s_start0 && !fault) ##1 (!i_stop && !ss_low && mfde_q && en) |=> mode_fault_flag_q)
    else $error("phase 0 deselect did not fault");
  AST_IDLE_NOFAULT: assert property (
    (!i_stop && !run && !master_select_alias && !mode_fault_flag_q && !wr_ctrl) |=> !mode_fault_flag_q)
    else $error("fault raised with no transfer");
  AST_TXE_WR: assert property (
    (!i_stop && wr_data && en && !load_tx) |=> !txe_q)
    else $error("data write did not clear tx empty");
  AST_DISABLED: assert property (
    (!i_stop && !en) |=> (txe_q && !run && edge_cnt_q == 5'h00 && shreg_q == 8'h00))
    else $error("disable did not reset engine");
  AST_RXF_SET: assert property (
    (!i_stop && rx_commit) |=> (rxf_q && rx_buf_q == $past(fin_byte)))
    else $error("received byte not stored");
  AST_BRK_HOLD: assert property (
    (!i_stop && frz && !rx_commit) |=> rxf_q == $past(rxf_q))
    else $error("flag cleared in frozen break");

endmodule

// File: bench/spi_peer.sv
// Purpose: far side of the serial link, plays master or slave
// Assumes: clock polarity 0; data out on leading edge, sampled on trailing
// Notes:   link clock period 80 ns; clock stands still outside frames
`timescale 1ns/10ps
module spi_peer (
  input  wire logic       i_master, // peer plays the master
  input  wire logic       i_go,     // rising: start frame or arm slave
  input  wire logic [3:0] i_nbits,  // bits per frame, 0 = select only
  input  wire logic [7:0] i_tx,     // byte the peer sends
  input  wire logic       i_sck,    // resolved clock wire
  input  wire logic       i_mosi,   // resolved master out wire
  input  wire logic       i_miso,   // resolved slave out wire
  output logic            o_drv,    // peer drives clock and master out
  output logic            o_sck,    // clock from peer as master
  output logic            o_mosi,   // master out from peer
  output logic            o_miso,   // slave out from peer
  output logic            o_ss_n,   // select towards the unit
  output logic      [7:0] o_rx,     // last byte received
  output logic      [7:0] o_nfr     // frames finished
);
  int bi = 0;

  initial
  begin
    o_drv = 1'b0;
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_miso = 1'b0;
    o_ss_n = 1'b1;
    o_rx = 8'h00;
    o_nfr = 8'h00;
  end

  // master frame: select, n clock cycles msb first, deselect
  always @(posedge i_go)
  begin
    bi = 0;
    if (i_master)
    begin
      o_ss_n = 1'b0;
      #40;
      o_drv = (i_nbits != 4'h0);
      for (int i = 0; i < 32'(i_nbits); i++)
      begin
        o_sck = 1'b1;
        o_mosi = i_tx[7-i];
        #40;
        o_sck = 1'b0;
        o_rx = {o_rx[6:0], i_miso};
        #40;
      end
      o_drv = 1'b0;
      o_mosi = ~o_mosi; // released line must not show a stale bit
      #40;
      o_ss_n = 1'b1;
      o_nfr = o_nfr + 8'h01;
    end
  end

  // slave side: bit out on leading edge
  always @(posedge i_sck)
    if (!i_master)
      o_miso = i_tx[7-bi];

  // slave side: sample on trailing edge, eight per byte
  always @(negedge i_sck)
    if (!i_master)
    begin
      o_rx = {o_rx[6:0], i_mosi};
      bi = (bi + 1) % 8;
      if (bi == 0)
      begin
        o_miso = ~o_miso; // hold time over, no stale level
        o_nfr = o_nfr + 8'h01;
      end
    end
endmodule

// File: bench/tb.sv
// Purpose: self-checking bench for the serial unit control block
// Assumes: register map and bit layout of spi_ctl_defs.svh
// Notes:   undriven clock wire is pulled down; expected rx bytes kept in a queue
`timescale 1ns/10ps
`include "spi_ctl_defs.svh"
module tb;
  logic       i_mclk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0, i_rd = 1'b0, i_wait = 1'b0, i_stop = 1'b0;
  logic       i_break = 1'b0, i_brk_clr_en = 1'b0;
  logic [7:0] o_rdata;
  logic       o_sck, o_sck_oe_n, o_mosi, o_mosi_oe_n, o_miso, o_miso_oe_n;
  logic       o_pins_owned, o_tx_irq, o_rx_irq, o_wake;
  logic       p_master = 1'b0, p_go = 1'b0, p_drv, p_sck, p_mosi, p_miso, p_ss_n;
  logic [3:0] p_nbits = 4'h0;
  logic [7:0] p_tx = 8'h00, p_rx, p_nfr, b, r, d, n0;
  logic [7:0] q[$];
  wire        sck_w, mosi_w, miso_w;
  int         n_fail = 0, checked = 0;

  always #2.5 i_mclk = ~i_mclk;

  // pin levels from the unit's enables; the clock also from the peer's
  assign sck_w  = !o_sck_oe_n ? o_sck : (p_drv ? p_sck : 1'b0);
  assign mosi_w = !o_mosi_oe_n ? o_mosi : p_mosi;
  assign miso_w = !o_miso_oe_n ? o_miso : p_miso;

  spi_ctl u_dut (.i_mclk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_wait, .i_stop, .i_break, .i_brk_clr_en, .i_ss_n(p_ss_n), .i_sck(sck_w),
    .o_sck, .o_sck_oe_n, .i_mosi(mosi_w), .o_mosi, .o_mosi_oe_n, .i_miso(miso_w),
    .o_miso, .o_miso_oe_n, .o_pins_owned, .o_tx_irq, .o_rx_irq, .o_wake);

  spi_peer u_peer (.i_master(p_master), .i_go(p_go), .i_nbits(p_nbits), .i_tx(p_tx),
    .i_sck(sck_w), .i_mosi(mosi_w), .i_miso(miso_w), .o_drv(p_drv), .o_sck(p_sck),
    .o_mosi(p_mosi), .o_miso(p_miso), .o_ss_n(p_ss_n), .o_rx(p_rx), .o_nfr(p_nfr));

  task automatic end_of_test;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  // bus cycles: strobe for one cycle, read data in the cycle after
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask

  task automatic rdc(input logic [1:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask

  // register outputs settle a few cycles after the cause
  task automatic settle;
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask

  task automatic wait_st(input int bt, input logic v);
    int k;
    k = 0;
    do
    begin
      rd(`SPI_ADDR_STAT);
      k++;
    end
    while (d[bt] !== v && k < 200);
    chk("status bit", 8'(v), 8'(d[bt]));
  endtask

  task automatic go(input logic m, input logic [3:0] n, input logic [7:0] t);
    @(posedge i_mclk);
    p_master <= m;
    p_nbits <= n;
    p_tx <= t;
    @(posedge i_mclk);
    p_go <= 1'b1;
    @(posedge i_mclk);
    p_go <= 1'b0;
  endtask

  task automatic wait_fr(input logic [7:0] c);
    int k;
    k = 0;
    while (p_nfr === c && k < 4000)
    begin
      @(posedge i_mclk);
      k++;
    end
    chk("frame done", 8'h00, 8'(k >= 4000));
  endtask

  task automatic do_reset;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rdc(`SPI_ADDR_CTRL, 8'h28, "ctrl");
    rdc(`SPI_ADDR_STAT, 8'h08, "status");
  endtask

  // watchdog: whole run is under a thousand cycles
  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial
  begin
    void'($urandom(40));
    do_reset();
    // unmapped place reads zero, drops writes
    rdc(2'h3, 8'h00, "unmapped");
    wr(2'h3, 8'hff);
    rdc(`SPI_ADDR_CTRL, 8'h28, "ctrl");
    // tx request needs unit enable
    wr(`SPI_ADDR_CTRL, 8'h29);
    settle();
    chk("tx irq off", 8'h00, 8'(o_tx_irq));
    go(1'b0, 4'h0, 8'h00);
    wr(`SPI_ADDR_CTRL, 8'h2b);
    settle();
    chk("tx irq on", 8'h01, 8'(o_tx_irq));
    chk("owned", 8'h01, 8'(o_pins_owned));
    // frozen break: data write ignored
    @(posedge i_mclk);
    i_break <= 1'b1;
    wr(`SPI_ADDR_DATA, 8'h55);
    settle();
    chk("tx irq in break", 8'h01, 8'(o_tx_irq));
    @(posedge i_mclk);
    i_break <= 1'b0;
    rdc(`SPI_ADDR_STAT, 8'h08, "status");
    // two master bytes unread: overrun
    wr(`SPI_ADDR_CTRL, 8'hab);
    // slowest baud leaves room for the two-flop input lag
    wr(`SPI_ADDR_STAT, 8'h43);
    for (int k = 0; k < 2; k++)
    begin
      r = 8'($urandom);
      b = 8'($urandom);
      go(1'b0, 4'h0, r);
      q.push_back(r);
      n0 = p_nfr;
      wr(`SPI_ADDR_DATA, b);
      wait_fr(n0);
      chk("peer rx", b, p_rx);
      wait_st(7, 1'b1);
    end
    wait_st(5, 1'b1);
    rdc(`SPI_ADDR_STAT, 8'heb, "status ovr");
    rdc(`SPI_ADDR_DATA, q[0], "rx data");
    rdc(`SPI_ADDR_STAT, 8'h4b, "status clr");
    // master sees select low
    wr(`SPI_ADDR_STAT, 8'h44);
    n0 = p_nfr;
    go(1'b1, 4'h0, 8'h00);
    wait_fr(n0);
    wait_st(4, 1'b1);
    rdc(`SPI_ADDR_CTRL, 8'ha9, "ctrl fault");
    chk("owned", 8'h00, 8'(o_pins_owned));
    chk("err irq", 8'h01, 8'(o_rx_irq));
    chk("tx irq dis", 8'h00, 8'(o_tx_irq));
    @(posedge i_mclk);
    i_break <= 1'b1;
    wr(`SPI_ADDR_CTRL, 8'ha9);
    rdc(`SPI_ADDR_STAT, 8'h5c, "fault in break");
    @(posedge i_mclk);
    i_break <= 1'b0;
    wr(`SPI_ADDR_CTRL, 8'ha9);
    rdc(`SPI_ADDR_STAT, 8'h4c, "fault cleared");
    // slave, phase 0: select alone faults
    wr(`SPI_ADDR_CTRL, 8'h02);
    n0 = p_nfr;
    go(1'b1, 4'h0, 8'h00);
    repeat (7) @(posedge i_mclk);
    @(negedge i_mclk);
    chk("miso driven", 8'h00, 8'(o_miso_oe_n));
    wait_fr(n0);
    settle();
    chk("miso float", 8'h01, 8'(o_miso_oe_n));
    wait_st(4, 1'b1);
    rdc(`SPI_ADDR_CTRL, 8'h02, "ctrl slave");
    chk("err irq", 8'h01, 8'(o_rx_irq));
    wr(`SPI_ADDR_CTRL, 8'h0a);
    n0 = p_nfr;
    go(1'b1, 4'h0, 8'h00);
    wait_fr(n0);
    settle();
    rdc(`SPI_ADDR_STAT, 8'h4c, "no fault ph1");
    // slave byte, phase 1
    r = 8'($urandom);
    b = 8'($urandom);
    wr(`SPI_ADDR_DATA, b);
    n0 = p_nfr;
    go(1'b1, 4'h8, r);
    wait_fr(n0);
    chk("peer rx", b, p_rx);
    wait_st(7, 1'b1);
    // disable keeps flags, rx request stays
    wr(`SPI_ADDR_CTRL, 8'h88);
    settle();
    rdc(`SPI_ADDR_STAT, 8'hcc, "status dis");
    chk("owned", 8'h00, 8'(o_pins_owned));
    chk("rx irq dis", 8'h01, 8'(o_rx_irq));
    rdc(`SPI_ADDR_DATA, r, "rx data");
    rdc(`SPI_ADDR_STAT, 8'h4c, "status clr");
    // wait mode closes the port, request wakes
    wr(`SPI_ADDR_CTRL, 8'h2b);
    @(posedge i_mclk);
    i_wait <= 1'b1;
    rdc(`SPI_ADDR_CTRL, 8'h00, "ctrl in wait");
    settle();
    chk("wake", 8'h01, 8'(o_wake));
    @(posedge i_mclk);
    i_wait <= 1'b0;
    do_reset();
    end_of_test();
  end
endmodule
